/* File: core/ctb_pkg.sv */
// shared definitions for the time-base trigger control block
// assumes a 32-bit avalon-mm register bus clocked by sys_clk
package ctb_pkg;
    localparam logic [3:0]  CTB_OFS_CTRL      = 4'h0;
    localparam logic [3:0]  CTB_OFS_STATUS    = 4'h4;
    localparam logic [3:0]  CTB_OFS_IRQ_FLAG  = 4'h8;
    localparam logic [3:0]  CTB_OFS_IRQ_MASK  = 4'hc;
    localparam int          CTB_POS_SYNC      = 0;
    localparam int          CTB_POS_SINGLE_SHOT_TRIGGER   = 6;
    localparam int          CTB_POS_TRIGON    = 7;
    localparam int          CTB_POS_OPS       = 8;
    localparam int          CTB_POS_RETRIG    = 14;
    localparam int          CTB_POS_OSCNT     = 16;
    localparam logic [15:0] CTB_CTRL_WMASK    = 16'h4fdf;
    localparam logic [14:0] CTB_CTRL_RESET    = 15'h0000;
    localparam logic [1:0]  CTB_IRQ_RESET     = 2'h0;
    localparam int          CTB_IRQ_POST      = 0;
    localparam int          CTB_IRQ_TRIG      = 1;

    typedef struct packed {
        logic [2:0] single_shot_length_count;
        logic       retrigger_allow;
        logic [3:0] interrupt_postscale_select;
        logic       time_base_trigger_on;
        logic       single_shot_trigger;
        logic [4:0] sync_source_select;
    } ctb_ctrl_s;

    typedef enum logic [1:0] {
        CTB_IDLE = 2'b00,
        CTB_HELD = 2'b01,
        CTB_RUN  = 2'b10
    } ctb_state_e;
endpackage : ctb_pkg

/* File: core/ctb_sync_sel.sv */
// selects one of 32 sync/trigger sources and gives a one-cycle rise pulse
// assumes sources arrive from outside the domain; two flops before use
`timescale 1ns/1ps
`default_nettype none
module ctb_sync_sel
    import ctb_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic [31:0] src_in,
    input  wire logic [4:0]  sel,
    output logic             pulse
);
    logic [31:0] meta;
    logic [31:0] stab;
    logic        prev;
    logic        next_pulse;

    always_comb begin
        next_pulse = stab[sel] & ~prev;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            meta  <= 32'h0;
            stab  <= 32'h0;
            prev  <= 1'b0;
            pulse <= 1'b0;
        end else begin
            meta  <= src_in;
            stab  <= meta;
            prev  <= stab[sel];
            pulse <= next_pulse;
        end
    end
endmodule : ctb_sync_sel
`default_nettype wire

/* File: core/ctb_time_base_trigger_ctrl.sv */
// time-base trigger, retrigger, one-shot and interrupt postscaler control
// assumes period_match is a one-cycle pulse on sys_clk from the time base
`timescale 1ns/1ps
`default_nettype none
module ctb_time_base_trigger_ctrl
    import ctb_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [31:0] sync_src_in,
    input  wire logic        period_match,
    output logic             time_base_run,
    output logic             time_base_reset,
    output logic             unit_irq_pulse,
    output logic             irq
);
    ctb_ctrl_s   ctrl;
    ctb_ctrl_s   next_ctrl;
    ctb_state_e  state;
    ctb_state_e  next_state;
    logic [3:0]  post_cnt;
    logic [3:0]  next_post_cnt;
    logic [2:0]  shot_cnt;
    logic [2:0]  next_shot_cnt;
    logic [1:0]  irq_flag;
    logic [1:0]  next_irq_flag;
    logic [1:0]  irq_mask;
    logic [1:0]  next_irq_mask;
    logic        ack;
    logic        next_ack;
    logic        next_waitrequest;
    logic [31:0] next_readdata;
    logic        next_run;
    logic        next_tb_reset;
    logic        next_unit_irq;
    logic        next_irq;
    logic        trig;
    logic        wr_hit;
    logic        post_fire;
    logic        trig_taken;

    ctb_sync_sel u_sel (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .src_in  (sync_src_in),
        .sel     (ctrl.sync_source_select),
        .pulse   (trig)
    );

    // bus: one wait cycle, answer on the second edge of each request
    // waitrequest idles high so it can come straight from a flop
    // writes land on the completion edge, where waitrequest is seen low
    always_comb begin
        next_ack      = (avs_read | avs_write) & ~ack;
        next_waitrequest = ~next_ack;
        wr_hit        = avs_write & ack;
        next_ctrl     = ctrl;
        next_irq_mask = irq_mask;
        next_readdata = avs_readdata;
        if (wr_hit && avs_address == CTB_OFS_CTRL) begin
            if (avs_byteenable[0]) begin
                next_ctrl.sync_source_select  = avs_writedata[CTB_POS_SYNC +: 5];
                next_ctrl.single_shot_trigger = avs_writedata[CTB_POS_SINGLE_SHOT_TRIGGER];
                next_ctrl.time_base_trigger_on = avs_writedata[CTB_POS_TRIGON];
            end
            if (avs_byteenable[1]) begin
                next_ctrl.interrupt_postscale_select = avs_writedata[CTB_POS_OPS +: 4];
                next_ctrl.retrigger_allow            = avs_writedata[CTB_POS_RETRIG];
            end
            if (avs_byteenable[2]) begin
                next_ctrl.single_shot_length_count = avs_writedata[CTB_POS_OSCNT +: 3];
            end
        end
        if (wr_hit && avs_address == CTB_OFS_IRQ_MASK && avs_byteenable[0]) begin
            next_irq_mask = avs_writedata[1:0];
        end
        if (avs_read && !ack) begin
            case (avs_address)
                CTB_OFS_CTRL: next_readdata = {13'h0, ctrl.single_shot_length_count,
                    1'b0, ctrl.retrigger_allow, 2'b00, ctrl.interrupt_postscale_select,
                    ctrl.time_base_trigger_on, ctrl.single_shot_trigger, 1'b0,
                    ctrl.sync_source_select} & {13'h0, 3'h7, CTB_CTRL_WMASK};
                CTB_OFS_STATUS:   next_readdata = {24'h0, 2'b00, state, 1'b0, shot_cnt};
                CTB_OFS_IRQ_FLAG: next_readdata = {30'h0, irq_flag};
                CTB_OFS_IRQ_MASK: next_readdata = {30'h0, irq_mask};
                default:          next_readdata = 32'h0;
            endcase
        end
    end

    // trigger state machine
    always_comb begin
        next_state    = state;
        next_shot_cnt = shot_cnt;
        next_tb_reset = 1'b0;
        trig_taken    = 1'b0;
        case (state)
            CTB_IDLE: begin
                next_state = ctrl.time_base_trigger_on ? CTB_HELD : CTB_RUN;
            end
            CTB_HELD: begin
                if (!ctrl.time_base_trigger_on) begin
                    next_state = CTB_RUN;
                end else if (trig) begin
                    next_state    = CTB_RUN;
                    next_tb_reset = 1'b1;
                    trig_taken    = 1'b1;
                    next_shot_cnt = ctrl.single_shot_length_count;
                end
            end
            CTB_RUN: begin
                if (!ctrl.time_base_trigger_on) begin
                    // arming triggers stops a free run until the next trigger
                    if (next_ctrl.time_base_trigger_on) begin
                        next_state = CTB_HELD;
                    end
                end else begin
                    if (trig && ctrl.retrigger_allow) begin
                        next_tb_reset = 1'b1;
                        trig_taken    = 1'b1;
                        next_shot_cnt = ctrl.single_shot_length_count;
                    end else if (ctrl.single_shot_trigger && period_match) begin
                        // one-shot: length count plus one period ends, then hold again
                        if (shot_cnt == 3'h0) begin
                            next_state = CTB_HELD;
                        end else begin
                            next_shot_cnt = shot_cnt - 3'h1;
                        end
                    end
                end
            end
            default: next_state = CTB_IDLE;
        endcase
        next_run = (next_state == CTB_RUN);
    end

    // postscaler and interrupt
    always_comb begin
        post_fire     = period_match && (post_cnt >= ctrl.interrupt_postscale_select);
        next_post_cnt = post_cnt;
        if (period_match) begin
            next_post_cnt = post_fire ? 4'h0 : post_cnt + 4'h1;
        end
        next_unit_irq = post_fire;
        next_irq_flag = irq_flag;
        if (wr_hit && avs_address == CTB_OFS_IRQ_FLAG && avs_byteenable[0]) begin
            next_irq_flag = irq_flag & ~avs_writedata[1:0];
        end
        // set wins over a simultaneous clear
        if (post_fire) next_irq_flag[CTB_IRQ_POST] = 1'b1;
        if (trig_taken) next_irq_flag[CTB_IRQ_TRIG] = 1'b1;
        next_irq = |(next_irq_flag & next_irq_mask);
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl            <= CTB_CTRL_RESET;
            state           <= CTB_IDLE;
            post_cnt        <= 4'h0;
            shot_cnt        <= 3'h0;
            irq_flag        <= CTB_IRQ_RESET;
            irq_mask        <= CTB_IRQ_RESET;
            ack             <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0;
            time_base_run   <= 1'b0;
            time_base_reset <= 1'b0;
            unit_irq_pulse  <= 1'b0;
            irq             <= 1'b0;
        end else begin
            ctrl            <= next_ctrl;
            state           <= next_state;
            post_cnt        <= next_post_cnt;
            shot_cnt        <= next_shot_cnt;
            irq_flag        <= next_irq_flag;
            irq_mask        <= next_irq_mask;
            ack             <= next_ack;
            avs_waitrequest <= next_waitrequest;
            avs_readdata    <= next_readdata;
            time_base_run   <= next_run;
            time_base_reset <= next_tb_reset;
            unit_irq_pulse  <= next_unit_irq;
            irq             <= next_irq;
        end
    end

    postscale_fire_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        period_match && post_cnt == ctrl.interrupt_postscale_select |=> unit_irq_pulse)
        else $error("postscaler missed its match");
    postscale_quiet_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        unit_irq_pulse |-> $past(period_match))
        else $error("interrupt without period match");
    trig_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        state == CTB_HELD && ctrl.time_base_trigger_on && !trig |=> !time_base_run)
        else $error("time base ran without trigger");
    trig_start_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        state == CTB_HELD && ctrl.time_base_trigger_on && trig |=> time_base_run && time_base_reset)
        else $error("trigger did not start time base");
    free_run_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        state != CTB_IDLE && !ctrl.time_base_trigger_on ##1 !ctrl.time_base_trigger_on
        |-> time_base_run)
        else $error("time base not free running");
    no_retrig_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        state == CTB_RUN && !ctrl.retrigger_allow |=> !time_base_reset)
        else $error("retrigger not ignored");
    shot_load_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        trig_taken |=> shot_cnt == $past(ctrl.single_shot_length_count))
        else $error("one-shot length not loaded");
    shot_end_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        state == CTB_RUN && ctrl.time_base_trigger_on && ctrl.single_shot_trigger
        && period_match && shot_cnt == 3'h0 && !trig |=> state == CTB_HELD)
        else $error("one-shot did not end");
    irq_level_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        irq == |(irq_flag & irq_mask))
        else $error("interrupt level wrong");

    trig_run_c: cover property (@(posedge sys_clk) disable iff (!resetn)
        state == CTB_HELD ##1 state == CTB_RUN);
    retrig_c: cover property (@(posedge sys_clk) disable iff (!resetn)
        state == CTB_RUN && time_base_reset);
    single_shot_trigger_c: cover property (@(posedge sys_clk) disable iff (!resetn)
        state == CTB_RUN && ctrl.single_shot_trigger ##1 state == CTB_HELD);
    irq_c: cover property (@(posedge sys_clk) disable iff (!resetn) irq);
endmodule : ctb_time_base_trigger_ctrl
`default_nettype wire

/* File: verification/tb_top.sv */
// self-checking bench for the time-base trigger control block
// assumes the block carries its own assertions; the bench drives every port itself
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import ctb_pkg::*;
;
    logic        sys_clk         = 1'b0;
    logic        resetn          = 1'b0;
    logic [3:0]  avs_address     = 4'h0;
    logic        avs_read        = 1'b0;
    logic        avs_write       = 1'b0;
    logic [31:0] avs_writedata   = 32'h0;
    logic [3:0]  avs_byteenable  = 4'hf;
    logic [31:0] sync_src_in     = 32'h0;
    logic        period_match    = 1'b0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        time_base_run;
    logic        time_base_reset;
    logic        unit_irq_pulse;
    logic        irq;
    int          fail_count      = 0;
    int          tests_run       = 0;
    int          pulse_cnt       = 0;
    int          tbr_cnt         = 0;
    int          ops, s, c, p0, t0, m1;
    logic [31:0] rd, d;

    ctb_time_base_trigger_ctrl dut (
        .sys_clk(sys_clk), .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sync_src_in(sync_src_in),
        .period_match(period_match), .time_base_run(time_base_run),
        .time_base_reset(time_base_reset), .unit_irq_pulse(unit_irq_pulse), .irq(irq)
    );

    always #4 sys_clk = ~sys_clk;

    // non-blocking so readers at the same edge see a stable count
    always @(posedge sys_clk) begin
        if (unit_irq_pulse === 1'b1) pulse_cnt <= pulse_cnt + 1;
        if (time_base_reset === 1'b1) tbr_cnt <= tbr_cnt + 1;
    end

    function automatic logic [31:0] ctrl_exp(input logic [31:0] v);
        return {13'h0, v[18:16], v[15:0] & CTB_CTRL_WMASK};
    endfunction : ctrl_exp

    function automatic int exp_pulses(input int o, input int m);
        return m / (o + 1);
    endfunction : exp_pulses

    task automatic wrap_up;
        if (fail_count == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask : chk

    task automatic bus_xfer(input logic wr, input logic [3:0] a, input logic [31:0] v);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address   <= a;
        avs_writedata <= v;
        avs_write     <= wr;
        avs_read      <= ~wr;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) chk("bus_answer", 32'h0, 32'h1);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : bus_xfer

    task automatic rst;
        @(posedge sys_clk);
        resetn <= 1'b0;
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
    endtask : rst

    task automatic pm(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            period_match <= 1'b1;
            @(posedge sys_clk);
            period_match <= 1'b0;
        end
        repeat (3) @(posedge sys_clk);
    endtask : pm

    // held high long enough to pass the two-flop synchroniser
    task automatic edge_src(input int k);
        @(posedge sys_clk);
        sync_src_in[k] <= 1'b1;
        repeat (4) @(posedge sys_clk);
        sync_src_in[k] <= 1'b0;
        repeat (10) @(posedge sys_clk);
    endtask : edge_src

    // a clean run needs under two thousand cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        wrap_up();
    end

    initial begin
        void'($urandom(4));
        rst();
        repeat (3) @(posedge sys_clk);
        chk("run_free", 32'h1, {31'h0, time_base_run});
        bus_xfer(1'b0, CTB_OFS_CTRL, 32'h0);
        chk("ctrl_reset", 32'h0, rd);
        bus_xfer(1'b0, 4'h2, 32'h0);
        chk("unmapped", 32'h0, rd);
        for (int i = 0; i < 6; i++) begin
            d = (i == 0) ? 32'hffffffff : $urandom;
            bus_xfer(1'b1, CTB_OFS_CTRL, d);
            bus_xfer(1'b0, CTB_OFS_CTRL, 32'h0);
            chk("ctrl_rw", ctrl_exp(d), rd);
        end
        // lane 0 only: upper lanes must keep their bits
        avs_byteenable <= 4'h1;
        bus_xfer(1'b1, CTB_OFS_CTRL, 32'h0);
        avs_byteenable <= 4'hf;
        bus_xfer(1'b0, CTB_OFS_CTRL, 32'h0);
        chk("ctrl_lane0", ctrl_exp({d[31:8], 8'h00}), rd);
        for (int i = 0; i < 3; i++) begin
            // no capture mode in this block, so every ratio is allowed
            ops = (i == 0) ? 4 : (i == 1) ? 15 : $urandom_range(0, 15);
            m1 = 2 * (ops + 1) - 1;
            rst();
            bus_xfer(1'b1, CTB_OFS_CTRL, ops << CTB_POS_OPS);
            p0 = pulse_cnt;
            pm(m1);
            chk("post_short", exp_pulses(ops, m1), pulse_cnt - p0);
            pm(1);
            chk("post_full", exp_pulses(ops, m1 + 1), pulse_cnt - p0);
        end
        bus_xfer(1'b0, CTB_OFS_IRQ_FLAG, 32'h0);
        chk("flag_post", 32'h1, rd);
        chk("irq_masked", 32'h0, {31'h0, irq});
        bus_xfer(1'b1, CTB_OFS_IRQ_MASK, 32'h1);
        repeat (2) @(posedge sys_clk);
        chk("irq_on", 32'h1, {31'h0, irq});
        bus_xfer(1'b1, CTB_OFS_IRQ_FLAG, 32'h1);
        repeat (2) @(posedge sys_clk);
        chk("irq_clear", 32'h0, {31'h0, irq});
        s = $urandom_range(0, 31);
        bus_xfer(1'b1, CTB_OFS_CTRL, 32'h80 | s);
        repeat (3) @(posedge sys_clk);
        chk("run_held", 32'h0, {31'h0, time_base_run});
        bus_xfer(1'b0, CTB_OFS_STATUS, 32'h0);
        chk("state_held", 32'h10, rd & 32'h30);
        t0 = tbr_cnt;
        edge_src(s ^ 1);
        chk("other_src", t0, tbr_cnt);
        edge_src(s);
        chk("trig_taken", t0 + 1, tbr_cnt);
        chk("run_started", 32'h1, {31'h0, time_base_run});
        edge_src(s);
        chk("retrig_off", t0 + 1, tbr_cnt);
        bus_xfer(1'b0, CTB_OFS_IRQ_FLAG, 32'h0);
        chk("flag_trig", 32'h2, rd & 32'h2);
        bus_xfer(1'b1, CTB_OFS_CTRL, 32'h4080 | s);
        edge_src(s);
        chk("retrig_on", t0 + 2, tbr_cnt);
        rst();
        c = $urandom_range(0, 7);
        bus_xfer(1'b1, CTB_OFS_CTRL, (c << CTB_POS_OSCNT) | 32'hc0 | s);
        edge_src(s);
        pm(c);
        chk("shot_running", 32'h1, {31'h0, time_base_run});
        pm(1);
        chk("shot_done", 32'h0, {31'h0, time_base_run});
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
